// [rtl/ssf_link_if.sv]
`timescale 1ns/100ps
`default_nettype none
// ==================================================
// Synchronised link events towards the core
interface ssf_link_if;
    logic bclk_rise;
    logic fsync;
    logic rx_bit;
    modport drv (output bclk_rise, output fsync, output rx_bit);
    modport core (input bclk_rise, input fsync, input rx_bit);
endinterface : ssf_link_if
`default_nettype wire

// [rtl/ssf_link_sync.sv]
`timescale 1ns/100ps
`default_nettype none
`include "ssf_regs.svh"
// ==================================================
// Pin synchronisers and bit clock edge finder
module ssf_link_sync
    import ssf_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic [`SSF_LNK_PINS-1:0] pins_raw,
    ssf_link_if.drv lnk
);
    logic [`SSF_LNK_PINS-1:0] meta_reg;
    logic [`SSF_LNK_PINS-1:0] sync_reg;
    logic bclk_prev_reg;

    // Two stages per pin; only the second stage feeds logic
    genvar g;
    generate
        for (g = 0; g < `SSF_LNK_PINS; g++) begin : g_pin
            always_ff @(posedge clock or negedge nrst) begin
                if (!nrst) begin
                    meta_reg[g] <= 1'b0;
                    sync_reg[g] <= 1'b0;
                end else if (clk_en) begin
                    meta_reg[g] <= pins_raw[g];
                    sync_reg[g] <= meta_reg[g];
                end
            end
        end
    endgenerate

    // Edge history of the synchronised bit clock
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            bclk_prev_reg <= 1'b0;
        end else if (clk_en) begin
            bclk_prev_reg <= sync_reg[`SSF_LNK_BCLK];
        end
    end

    // One-cycle pulse per rising bit clock edge
    assign lnk.bclk_rise = sync_reg[`SSF_LNK_BCLK] & ~bclk_prev_reg;
    assign lnk.fsync = sync_reg[`SSF_LNK_FSYNC];
    assign lnk.rx_bit = sync_reg[`SSF_LNK_RXD];
endmodule : ssf_link_sync
`default_nettype wire

// [rtl/ssf_pkg.sv]
package ssf_pkg;
    // Frame tracking state
    typedef enum logic {
        SSF_IDLE = 1'b0,
        SSF_ACTIVE = 1'b1
    } ssf_frame_t;
    typedef logic [23:0] ssf_word_t;
endpackage : ssf_pkg

// [rtl/ssf_regs.svh]
`ifndef SSF_REGS_SVH
`define SSF_REGS_SVH
// ==================================================
// Register map (byte addresses)
`define SSF_ADDR_W 5
`define SSF_OFF_CTRL 5'h00
`define SSF_OFF_STATUS 5'h04
`define SSF_OFF_RXHOLD 5'h08
`define SSF_OFF_TX0 5'h0C
`define SSF_OFF_SKIP 5'h18
`define SSF_REG_STRIDE 5'h04
`define SSF_RESP_OK 2'h0
`define SSF_RESP_ERR 2'h2
// ==================================================
// Control register fields
`define SSF_CB_OF0 0
`define SSF_CB_OF1 1
`define SSF_CB_DIR0 2
`define SSF_CB_DIR1 3
`define SSF_CB_NET 8
`define SSF_CB_SYNC 9
`define SSF_CB_TX0 10
`define SSF_CB_TX2 12
`define SSF_CB_RXON 13
`define SSF_CB_RIE 14
`define SSF_CB_TIE 15
`define SSF_CB_OVERRUN_IRQ_EN 16
`define SSF_CB_UNDERRUN_IRQ_EN 17
`define SSF_CTRL_MASK 24'h03FF0F
`define SSF_CTRL_RST 24'h000000
// ==================================================
// Status register fields
`define SSF_SR_RDF 7
`define SSF_SR_TDE 6
`define SSF_SR_ROE 5
`define SSF_SR_TUE 4
`define SSF_SR_RFS 3
`define SSF_SR_TFS 2
// ==================================================
// Link framing
`define SSF_LNK_PINS 3
`define SSF_LNK_BCLK 0
`define SSF_LNK_FSYNC 1
`define SSF_LNK_RXD 2
`define SSF_WORD_MSB 7
`define SSF_BIT_W 3
`define SSF_BIT_ZERO 3'h0
`define SSF_BIT_ONE 3'h1
`define SSF_BIT_LAST 3'h7
`define SSF_SLOT_W 5
`define SSF_SLOT_ZERO 5'h00
`define SSF_SLOT_ONE 5'h01
`define SSF_SLOT_LAST 5'h1F
`define SSF_NUM_TX 3
`endif

// [rtl/ssf_top.sv]
// Notes on behaviour
// R1: Pin1 direction from its bit unless tx2
// R2: Transmitter 2 on forces pin1 output
// R3: Pin0 direction from its bit unless tx1
// R4: Transmitter 1 on forces pin0 output
// R5: Flag1 driven on pin1 at frame/slot
// R6: Flag0 driven on pin0 at frame/slot
// R7: Status read-only, upper bits read zero
// R8: Receive full set on transfer, read clears
// R9: Transmit empty set when holdings transferred
// R10: Skipped slot also sets transmit empty
// R11: Writing all holdings or skip clears empty
// R12: Overrun when new word meets full flag
// R13: Overrun cleared by status then receive read
// R14: Underrun when slot finds stale holding
// R15: Underrun resends previous holding word
// R16: One slot normal, up to 32 network
// R17: Underrun cleared by status read, then writes
// R18: Receive frame flag marks first-slot word
// R19: Normal mode receive frame flag reads one
// R20: Transmit frame flag only in first slot
// R21: First-slot writes go in second slot
// R22: Transmit frame flag valid with transmitter on
// R23: Skipped slot floats enabled data outputs
// R24: Status stale two cycles after writes
// R25: Slot counter restarts at each frame sync
//
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "ssf_regs.svh"
module ssf_top
    import ssf_pkg::*;
(
    input wire logic CLOCK,
    input wire logic NRST,
    input wire logic CLK_EN,
    input wire logic [`SSF_ADDR_W-1:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [`SSF_ADDR_W-1:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    input wire logic BIT_CLK,
    input wire logic FSYNC,
    input wire logic RX_DATA,
    output logic TX_DATA0_O,
    output logic TX_DATA0_OE,
    input wire logic CTL_PIN0_I,
    output logic CTL_PIN0_O,
    output logic CTL_PIN0_OE,
    input wire logic CTL_PIN1_I,
    output logic CTL_PIN1_O,
    output logic CTL_PIN1_OE,
    output logic RX_REQ,
    output logic TX_REQ,
    output logic OVR_REQ,
    output logic UNR_REQ
);
    // ==================================================
    // Declarations
    ssf_link_if lnk();
    ssf_frame_t frame_reg, frame_next;
    ssf_word_t ctrl_reg, rx_hold_reg, wmask;
    ssf_word_t hold_reg [`SSF_NUM_TX];
    logic [`SSF_WORD_MSB:0] tx_shift_reg [`SSF_NUM_TX];
    logic [`SSF_WORD_MSB:0] rx_shift_reg;
    logic [`SSF_BIT_W-1:0] bit_cnt_reg, idx;
    logic [`SSF_SLOT_W-1:0] slot_cnt_reg;
    logic [`SSF_NUM_TX-1:0] tx_on, wr_tx_vec, fresh_reg;
    logic [1:0] flag_reg;
    logic [31:0] rd_value, status_w;
    logic [1:0] rd_resp;
    logic aw_take, ar_take, wr_ctrl, wr_skip, rd_status, rd_rx, rd_ok;
    logic rise, in_slot, slot_go, word_end, frame_last, net, any_tx;
    logic rx_xfer, rx_first_reg, rfs_reg, tfs_reg;
    logic rdf_reg, tde_reg, roe_reg, tue_reg, roe_arm_reg, tue_arm_reg;
    logic tx_load, tx_skip, all_wr, tue_clr, skip_pend_reg, skip_slot_reg;
    logic bvalid_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;

    // Word-aligned address compare, shared by both channels
    function automatic logic hit(input logic [`SSF_ADDR_W-1:0] a, input logic [`SSF_ADDR_W-1:0] off);
        return a[`SSF_ADDR_W-1:2] == off[`SSF_ADDR_W-1:2];
    endfunction : hit

    ssf_link_sync u_sync (
        .clock(CLOCK),
        .nrst(NRST),
        .clk_en(CLK_EN),
        .pins_raw({RX_DATA, FSYNC, BIT_CLK}),
        .lnk(lnk.drv)
    );

    // ==================================================
    // Bus slave: address and data taken together
    assign aw_take = AWVALID & WVALID & ~bvalid_reg & CLK_EN;
    assign AWREADY = aw_take;
    assign WREADY = aw_take;
    assign ar_take = ARVALID & ~rvalid_reg & CLK_EN;
    assign ARREADY = ar_take;
    assign BVALID = bvalid_reg;
    assign BRESP = bresp_reg;
    assign RVALID = rvalid_reg;
    assign RRESP = rresp_reg;
    assign RDATA = rdata_reg;
    assign wmask = {{8{WSTRB[2]}}, {8{WSTRB[1]}}, {8{WSTRB[0]}}};
    assign wr_ctrl = aw_take & hit(AWADDR, `SSF_OFF_CTRL);
    assign wr_skip = aw_take & hit(AWADDR, `SSF_OFF_SKIP);
    assign rd_status = ar_take & hit(ARADDR, `SSF_OFF_STATUS);
    assign rd_rx = ar_take & hit(ARADDR, `SSF_OFF_RXHOLD);
    assign rd_ok = rd_status | rd_rx | hit(ARADDR, `SSF_OFF_CTRL);

    // Status image; upper bits stay zero, writes to it are dropped
    always_comb begin
        status_w = '0; // R7
        status_w[`SSF_SR_RDF] = rdf_reg;
        status_w[`SSF_SR_TDE] = tde_reg;
        status_w[`SSF_SR_ROE] = roe_reg;
        status_w[`SSF_SR_TUE] = tue_reg;
        status_w[`SSF_SR_RFS] = ctrl_reg[`SSF_CB_RXON] & (~net | rfs_reg); // R18 R19
        status_w[`SSF_SR_TFS] = any_tx & tfs_reg; // R22
    end

    // Read mux; unmapped and write-only offsets answer with an error
    always_comb begin
        rd_value = 32'h0000_0000;
        rd_resp = `SSF_RESP_OK;
        if (hit(ARADDR, `SSF_OFF_CTRL)) begin
            rd_value = {8'h00, ctrl_reg};
        end else if (hit(ARADDR, `SSF_OFF_STATUS)) begin
            rd_value = status_w;
        end else if (hit(ARADDR, `SSF_OFF_RXHOLD)) begin
            rd_value = {8'h00, rx_hold_reg};
        end
        if (!rd_ok) begin
            rd_resp = `SSF_RESP_ERR;
        end
    end

    // Write response
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= `SSF_RESP_OK;
        end else if (CLK_EN) begin
            if (aw_take) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= (wr_ctrl | wr_skip | (|wr_tx_vec) | hit(AWADDR, `SSF_OFF_STATUS))
                    ? `SSF_RESP_OK : `SSF_RESP_ERR;
            end else if (BREADY) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // Read response, data held until taken
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            rvalid_reg <= 1'b0;
            rresp_reg <= `SSF_RESP_OK;
            rdata_reg <= 32'h0000_0000;
        end else if (CLK_EN) begin
            if (ar_take) begin
                rvalid_reg <= 1'b1;
                rresp_reg <= rd_resp;
                rdata_reg <= rd_value;
            end else if (RREADY) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    // Control register with byte lanes
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            ctrl_reg <= `SSF_CTRL_RST;
        end else if (CLK_EN && wr_ctrl) begin
            ctrl_reg <= ((WDATA[23:0] & wmask) | (ctrl_reg & ~wmask)) & `SSF_CTRL_MASK;
        end
    end
    assign tx_on = ctrl_reg[`SSF_CB_TX2:`SSF_CB_TX0];
    assign any_tx = |tx_on;
    assign net = ctrl_reg[`SSF_CB_NET];

    // ==================================================
    // Framing: bit and slot counters on bit clock edges
    assign rise = lnk.bclk_rise & CLK_EN;
    assign in_slot = lnk.fsync | (frame_reg == SSF_ACTIVE);
    assign idx = lnk.fsync ? `SSF_BIT_ZERO : bit_cnt_reg;
    assign slot_go = rise & (lnk.fsync | ((frame_reg == SSF_ACTIVE) & (bit_cnt_reg == `SSF_BIT_ZERO)));
    assign word_end = rise & in_slot & (idx == `SSF_BIT_LAST);
    assign frame_last = ~net | (slot_cnt_reg == `SSF_SLOT_LAST); // R16

    always_comb begin
        case (frame_reg)
            SSF_IDLE: frame_next = lnk.fsync ? SSF_ACTIVE : SSF_IDLE;
            SSF_ACTIVE: frame_next = (word_end & frame_last) ? SSF_IDLE : SSF_ACTIVE;
            default: frame_next = SSF_IDLE;
        endcase
    end

    // Counters restart on every frame sync
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            frame_reg <= SSF_IDLE;
            bit_cnt_reg <= `SSF_BIT_ZERO;
            slot_cnt_reg <= `SSF_SLOT_ZERO;
        end else if (rise) begin
            frame_reg <= frame_next;
            if (lnk.fsync) begin
                bit_cnt_reg <= `SSF_BIT_ONE; // R25
                slot_cnt_reg <= `SSF_SLOT_ZERO; // R25
            end else if (frame_reg == SSF_ACTIVE) begin
                bit_cnt_reg <= bit_cnt_reg + `SSF_BIT_ONE;
                if (word_end && !frame_last) begin
                    slot_cnt_reg <= slot_cnt_reg + `SSF_SLOT_ONE; // R16
                end
            end
        end
    end

    // ==================================================
    // Receive path
    assign rx_xfer = word_end & ctrl_reg[`SSF_CB_RXON];

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            rx_shift_reg <= '0;
            rx_first_reg <= 1'b0;
            rx_hold_reg <= '0;
            rfs_reg <= 1'b0;
        end else if (CLK_EN) begin
            if (rise && in_slot) begin
                rx_shift_reg <= {rx_shift_reg[`SSF_WORD_MSB-1:0], lnk.rx_bit};
                if (idx == `SSF_BIT_ZERO) begin
                    rx_first_reg <= lnk.fsync;
                end
            end
            // A word meeting a full holding is dropped
            if (rx_xfer && (!rdf_reg || rd_rx)) begin
                rx_hold_reg <= ssf_word_t'({rx_shift_reg[`SSF_WORD_MSB-1:0], lnk.rx_bit});
                rfs_reg <= rx_first_reg; // R18
            end
        end
    end

    // Receive flags; a new event beats a same-cycle clear
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            rdf_reg <= 1'b0;
            roe_reg <= 1'b0;
            roe_arm_reg <= 1'b0;
        end else if (CLK_EN) begin
            if (rx_xfer) begin
                rdf_reg <= 1'b1; // R8
            end else if (rd_rx) begin
                rdf_reg <= 1'b0; // R8
            end
            if (rx_xfer && rdf_reg && !rd_rx) begin
                roe_reg <= 1'b1; // R12
                roe_arm_reg <= roe_arm_reg;
            end else if (rd_rx && roe_arm_reg) begin
                roe_reg <= 1'b0; // R13
                roe_arm_reg <= 1'b0;
            end else if (rd_status && roe_reg) begin
                roe_arm_reg <= 1'b1; // R13
            end
        end
    end

    // ==================================================
    // Transmit path
    genvar g;
    generate
        for (g = 0; g < `SSF_NUM_TX; g++) begin : g_tx
            assign wr_tx_vec[g] = aw_take & hit(AWADDR, `SSF_ADDR_W'(`SSF_OFF_TX0 + `SSF_REG_STRIDE * g));
            // Holding keeps its old word, so a missed write resends it
            always_ff @(posedge CLOCK or negedge NRST) begin
                if (!NRST) begin
                    hold_reg[g] <= '0;
                    tx_shift_reg[g] <= '0;
                end else if (CLK_EN) begin
                    if (wr_tx_vec[g]) begin
                        hold_reg[g] <= (WDATA[23:0] & wmask) | (hold_reg[g] & ~wmask);
                    end
                    if (tx_load) begin
                        tx_shift_reg[g] <= hold_reg[g][`SSF_WORD_MSB:0]; // R15
                    end else if (rise && in_slot) begin
                        tx_shift_reg[g] <= {tx_shift_reg[g][`SSF_WORD_MSB-1:0], 1'b0};
                    end
                end
            end
        end
    endgenerate

    assign tx_load = slot_go & any_tx & ~skip_pend_reg;
    assign tx_skip = slot_go & any_tx & skip_pend_reg;
    assign all_wr = (|wr_tx_vec) & (((fresh_reg | wr_tx_vec) & tx_on) == tx_on);
    assign tue_clr = tue_arm_reg & (all_wr | wr_skip);

    // Slot bookkeeping; a write during a load is kept for the next slot
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            fresh_reg <= '0;
            skip_pend_reg <= 1'b0;
            skip_slot_reg <= 1'b0;
            tfs_reg <= 1'b0;
        end else if (CLK_EN) begin
            fresh_reg <= tx_load ? wr_tx_vec : (fresh_reg | wr_tx_vec); // R21
            if (wr_skip) begin
                skip_pend_reg <= 1'b1;
            end else if (tx_skip) begin
                skip_pend_reg <= 1'b0;
            end
            if (slot_go && any_tx) begin
                skip_slot_reg <= skip_pend_reg; // R23
            end
            if (slot_go) begin
                tfs_reg <= lnk.fsync; // R20
            end
        end
    end

    // Transmit flags; a set beats a same-cycle clear
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            tde_reg <= 1'b0;
            tue_reg <= 1'b0;
            tue_arm_reg <= 1'b0;
        end else if (CLK_EN) begin
            if (tx_load || tx_skip) begin
                tde_reg <= 1'b1; // R9 R10
            end else if (all_wr || wr_skip) begin
                tde_reg <= 1'b0; // R11
            end
            if (tx_load && |(tx_on & ~fresh_reg)) begin
                tue_reg <= 1'b1; // R14
            end else if (tue_clr) begin
                tue_reg <= 1'b0; // R17
                tue_arm_reg <= 1'b0;
            end else if (rd_status && tue_reg) begin
                tue_arm_reg <= 1'b1; // R17
            end
        end
    end

    // Output flags follow control at frame or slot starts
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            flag_reg <= 2'h0;
        end else if (slot_go && ctrl_reg[`SSF_CB_SYNC] && (net || lnk.fsync)) begin
            flag_reg <= ctrl_reg[`SSF_CB_OF1:`SSF_CB_OF0]; // R5 R6
        end
    end

    // ==================================================
    // Registered pins and requests
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            TX_DATA0_O <= 1'b0;
            TX_DATA0_OE <= 1'b0;
            CTL_PIN0_O <= 1'b0;
            CTL_PIN0_OE <= 1'b0;
            CTL_PIN1_O <= 1'b0;
            CTL_PIN1_OE <= 1'b0;
            RX_REQ <= 1'b0;
            TX_REQ <= 1'b0;
            OVR_REQ <= 1'b0;
            UNR_REQ <= 1'b0;
        end else if (CLK_EN) begin
            TX_DATA0_O <= tx_shift_reg[0][`SSF_WORD_MSB];
            TX_DATA0_OE <= tx_on[0] & ~skip_slot_reg; // R23
            // Transmitters 1 and 2 own the control pins when on
            CTL_PIN0_O <= tx_on[1] ? tx_shift_reg[1][`SSF_WORD_MSB] : (ctrl_reg[`SSF_CB_SYNC] & flag_reg[0]); // R6
            CTL_PIN0_OE <= tx_on[1] ? ~skip_slot_reg : ctrl_reg[`SSF_CB_DIR0]; // R3 R4
            CTL_PIN1_O <= tx_on[2] ? tx_shift_reg[2][`SSF_WORD_MSB] : (ctrl_reg[`SSF_CB_SYNC] & flag_reg[1]); // R5
            CTL_PIN1_OE <= tx_on[2] ? ~skip_slot_reg : ctrl_reg[`SSF_CB_DIR1]; // R1 R2
            RX_REQ <= rdf_reg & ctrl_reg[`SSF_CB_RIE]; // R8
            TX_REQ <= tde_reg & ctrl_reg[`SSF_CB_TIE]; // R11
            OVR_REQ <= roe_reg & ctrl_reg[`SSF_CB_OVERRUN_IRQ_EN]; // R12
            UNR_REQ <= tue_reg & ctrl_reg[`SSF_CB_UNDERRUN_IRQ_EN]; // R14
        end
    end

    // ==================================================
    // Checks
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!NRST);

    rdf_set_a: assert property (rx_xfer |=> rdf_reg) else $error("receive full not set"); // R8
    rdf_clr_a: assert property (rd_rx && !rx_xfer |=> !rdf_reg) else $error("receive full not cleared"); // R8
    ovr_set_a: assert property (rx_xfer && rdf_reg && !rd_rx |=> roe_reg ##1
        (OVR_REQ || !$past(CLK_EN) || !$past(ctrl_reg[`SSF_CB_OVERRUN_IRQ_EN])))
        else $error("overrun missed"); // R12
    tde_set_a: assert property (tx_load || tx_skip |=> tde_reg) else $error("transmit empty not set"); // R9
    unr_set_a: assert property (tx_load && |(tx_on & ~fresh_reg) |=> tue_reg) else $error("underrun missed"); // R14
    skip_float_a: assert property (tx_skip && tx_on[0] ##1 CLK_EN |=> !TX_DATA0_OE)
        else $error("skipped slot driven"); // R23
    pin1_force_a: assert property ($past(tx_on[2]) && !$past(skip_slot_reg) && $past(CLK_EN) |-> CTL_PIN1_OE)
        else $error("pin1 not output"); // R2
    pin0_input_a: assert property ($past(!tx_on[1] && !ctrl_reg[`SSF_CB_DIR0] && CLK_EN) |-> !CTL_PIN0_OE)
        else $error("pin0 driven as input"); // R3
    tfs_clear_a: assert property (slot_go && !lnk.fsync |=> !tfs_reg) else $error("frame flag in later slot"); // R20
    slot_one_a: assert property (frame_reg == SSF_ACTIVE && !net |-> slot_cnt_reg == `SSF_SLOT_ZERO)
        else $error("extra slot in normal mode"); // R16
    resend_a: assert property (tx_load && !fresh_reg[0] |=> tx_shift_reg[0] == $past(hold_reg[0][`SSF_WORD_MSB:0]))
        else $error("old word not resent"); // R15

    ovr_seen_c: cover property (rx_xfer && rdf_reg && !rd_rx);
    unr_seen_c: cover property (tx_load && |(tx_on & ~fresh_reg));
    skip_seen_c: cover property (tx_skip);
    net_slot_c: cover property (slot_go && net && slot_cnt_reg == `SSF_SLOT_ONE);
endmodule : ssf_top
`default_nettype wire

// [tb/ssf_codec.sv]
`timescale 1ns/100ps
`default_nettype none
// ==================================================
// Serial codec on the frame link
module ssf_codec (
    output logic BIT_CLK,
    output logic FSYNC,
    output logic RX_DATA,
    input wire logic TX_DATA0_O,
    input wire logic TX_DATA0_OE
);
    // Bit clock stands still between frames
    initial begin
        BIT_CLK = 1'b0;
        FSYNC = 1'b0;
        RX_DATA = 1'b0;
    end
    // One 8-bit slot, MSB first; a tx bit is read at the following rise, clear of its update
    task automatic frame(input logic [7:0] rx, output logic [7:0] tx, output logic oe);
        oe = 1'b0;
        #2; // Off the system clock edge, so the pins never race it
        for (int i = 0; i < 9; i++) begin
            FSYNC = (i == 0);
            RX_DATA = (i < 8) ? rx[7-i] : rx[0];
            #40;
            BIT_CLK = 1'b1;
            if (i > 0) begin
                tx[8-i] = TX_DATA0_O;
                oe = oe | TX_DATA0_OE;
            end
            #40;
            BIT_CLK = 1'b0;
        end
        // Released line shows the inverse, never a stale bit
        RX_DATA = ~RX_DATA;
        FSYNC = 1'b0;
    endtask : frame
endmodule : ssf_codec
`default_nettype wire

// [tb/sync_serial_flags_and_status_tb.sv]
`timescale 1ns/100ps
`default_nettype none
`include "ssf_regs.svh"
module sync_serial_flags_and_status_tb;
    logic CLOCK, NRST, AWVALID, WVALID, BREADY, ARVALID, RREADY, BIT_CLK, FSYNC, RX_DATA;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, TX_DATA0_O, TX_DATA0_OE, RX_REQ, TX_REQ;
    logic CTL_PIN0_O, CTL_PIN0_OE, CTL_PIN1_O, CTL_PIN1_OE, OVR_REQ, UNR_REQ, oe;
    logic [4:0] AWADDR, ARADDR, c;
    logic [31:0] WDATA, RDATA, v;
    logic [3:0] WSTRB;
    logic [1:0] BRESP, RRESP;
    logic [7:0] r1, r2, r3, b1, t;
    logic [33:0] rq[$];
    logic [31:0] mq[$];
    logic [1:0] bq[$];
    int n_fail = 0;
    int num_checks = 0;
    // ==================================================
    // Clock, design and codec
    initial begin
        CLOCK = 1'b0;
        forever #4 CLOCK = ~CLOCK;
    end
    ssf_top dut (.CLOCK(CLOCK), .NRST(NRST), .CLK_EN(1'b1), .AWADDR(AWADDR), .AWVALID(AWVALID),
        .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
        .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
        .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
        .BIT_CLK(BIT_CLK), .FSYNC(FSYNC), .RX_DATA(RX_DATA), .TX_DATA0_O(TX_DATA0_O),
        .TX_DATA0_OE(TX_DATA0_OE), .CTL_PIN0_I(1'b0), .CTL_PIN0_O(CTL_PIN0_O), .CTL_PIN0_OE(CTL_PIN0_OE),
        .CTL_PIN1_I(1'b0), .CTL_PIN1_O(CTL_PIN1_O), .CTL_PIN1_OE(CTL_PIN1_OE), .RX_REQ(RX_REQ),
        .TX_REQ(TX_REQ), .OVR_REQ(OVR_REQ), .UNR_REQ(UNR_REQ));
    ssf_codec u_codec (.BIT_CLK(BIT_CLK), .FSYNC(FSYNC), .RX_DATA(RX_DATA),
        .TX_DATA0_O(TX_DATA0_O), .TX_DATA0_OE(TX_DATA0_OE));
    // ==================================================
    // Checking and bus tasks
    task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge CLOCK);
    endtask : cyc
    task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
        bq.push_back(r);
        @(posedge CLOCK);
        AWADDR <= a;
        WDATA <= d;
        WSTRB <= 4'hF;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        do @(posedge CLOCK); while (AWREADY !== 1'b1);
        AWVALID <= 1'b0;
        WVALID <= 1'b0;
        do @(posedge CLOCK); while (BVALID !== 1'b1);
        BREADY <= 1'b0;
    endtask : wr
    // Mask hides status bits whose value is not pinned down here
    task automatic rd(input logic [4:0] a, input logic [33:0] e, input logic [31:0] m);
        rq.push_back(e);
        mq.push_back(m);
        @(posedge CLOCK);
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        do @(posedge CLOCK); while (ARREADY !== 1'b1);
        ARVALID <= 1'b0;
        do @(posedge CLOCK); while (RVALID !== 1'b1);
        RREADY <= 1'b0;
    endtask : rd
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop
    // Response watcher takes the oldest note
    always @(posedge CLOCK) begin
        if (RVALID === 1'b1 && RREADY === 1'b1 && rq.size() > 0) begin
            chk("rdata", {RRESP, RDATA & mq.pop_front()}, rq.pop_front());
        end
        if (BVALID === 1'b1 && BREADY === 1'b1 && bq.size() > 0) begin
            chk("bresp", {32'h0, BRESP}, {32'h0, bq.pop_front()});
        end
    end
    // Watchdog well past the expected run length
    initial begin
        repeat (20000) @(posedge CLOCK);
        n_fail++;
        report_and_stop();
    end
    // ==================================================
    // Main sequence
    initial begin
        {NRST, AWVALID, WVALID, BREADY, ARVALID, RREADY, AWADDR, ARADDR, WDATA, WSTRB} = '0;
        void'($urandom(32'hED33268E));
        repeat (6) @(posedge CLOCK);
        NRST <= 1'b1;
        rd(5'h04, 34'h0, 32'hFFFFFFFF);
        wr(5'h04, 32'hFFFFFF, 2'h0);
        rd(5'h04, 34'h0, 32'hFFFFFFFF);
        rd(5'h1C, {2'h2, 32'h0}, 32'hFFFFFFFF);
        wr(5'h1C, 32'h0, 2'h2);
        v = $urandom;
        wr(5'h00, v, 2'h0);
        rd(5'h00, {10'h0, v[23:0] & `SSF_CTRL_MASK}, 32'hFFFFFFFF);
        // Every mix of sync bit, direction bits and transmitters 1 and 2
        for (int i = 0; i < 32; i++) begin
            c = i[4:0];
            wr(5'h00, {19'h0, c[3:2], 1'b0, c[4], 5'h0, c[1:0], 2'h0}, 2'h0);
            cyc(4);
            chk("pin0_oe", {33'h0, CTL_PIN0_OE}, {33'h0, c[0] | c[2]});
            chk("pin1_oe", {33'h0, CTL_PIN1_OE}, {33'h0, c[1] | c[3]});
        end
        {r1, r2, r3, b1} = $urandom;
        wr(5'h00, 32'h3660F, 2'h0);
        cyc(4);
        chk("pin0_o", {33'h0, CTL_PIN0_O}, 34'h0);
        wr(5'h0C, {24'h0, b1}, 2'h0);
        u_codec.frame(r1, t, oe);
        cyc(8);
        chk("tx_word", {26'h0, t}, {26'h0, b1});
        chk("pin0_o", {33'h0, CTL_PIN0_O}, 34'h1);
        chk("pin1_o", {33'h0, CTL_PIN1_O}, 34'h1);
        chk("rx_req", {33'h0, RX_REQ}, 34'h1);
        rd(5'h04, 34'hCC, 32'hFC);
        rd(5'h08, {26'h0, r1}, 32'hFFFFFFFF);
        rd(5'h04, 34'h0, 32'h80);
        // No fresh transmit word: underrun resends the old one
        u_codec.frame(r2, t, oe);
        cyc(8);
        chk("resend", {26'h0, t}, {26'h0, b1});
        chk("unr_req", {33'h0, UNR_REQ}, 34'h1);
        rd(5'h04, 34'h10, 32'h10);
        // Holding left full: overrun keeps the older word
        u_codec.frame(r3, t, oe);
        cyc(8);
        chk("ovr_req", {33'h0, OVR_REQ}, 34'h1);
        rd(5'h04, 34'h20, 32'h20);
        rd(5'h08, {26'h0, r2}, 32'hFFFFFFFF);
        rd(5'h04, 34'h0, 32'h20);
        wr(5'h0C, {24'h0, b1}, 2'h0);
        rd(5'h04, 34'h0, 32'h50);
        // Skipped slot floats the data pin
        wr(5'h18, 32'h0, 2'h0);
        u_codec.frame(r1, t, oe);
        cyc(8);
        chk("skip_oe", {33'h0, oe}, 34'h0);
        // Network mode: second slot reloads stale data, not frame start
        wr(5'h00, 32'h3670F, 2'h0);
        wr(5'h0C, {24'h0, b1}, 2'h0);
        u_codec.frame(r2, t, oe);
        cyc(8);
        rd(5'h04, 34'h10, 32'h14);
        cyc(4);
        report_and_stop();
    end
endmodule : sync_serial_flags_and_status_tb
`default_nettype wire
